// ---- logic/sfb_fifo.sv ----
`timescale 1ns/1ns
// Function
// - 512-byte store of measurement frames
// - writing off unless enabled with a quantity
// - disabled writing keeps read, flush, synth frames
// - source select 01 stores filtered results
// - count split: msb high register, low byte
// - count moves only by whole frames
// - normal mode keeps one of 2^N
// - sleep to normal resets decimation, stores first
// - reads never blocked, never block writes
// - burst address stops at data register
// - full when free space below nine
// - streaming drops oldest frames until fits
// - stop-on-full drops incoming frames while full
// - header: type, parameter, two zero bits
// - sensor and control frame types, parameters
// - header flags time, temperature, pressure
// - time frame: three time bytes, low first
// - time frame not stored, appended per burst
// - temperature then pressure, low byte first
// - empty frame when nothing left to read
// - config error stores error control frame
// - one control frame for settings changes in normal mode, written before the next sensor frame
// - flush or soft reset command empties store
// - partial frame resent unless overwritten
module sfb_fifo (
   input  wire logic        CLK,            // core clock, 20 MHz
   input  wire logic        RESET,          // synchronous, active high
   input  wire logic        BUF_ENABLE,     // buffer enable
   input  wire logic        PRESS_STORE_EN, // store pressure
   input  wire logic        TEMP_STORE_EN,  // store temperature
   input  wire logic        STOP_ON_FULL,   // 1: drop new, 0: stream
   input  wire logic        TIME_APPEND_EN, // append time frame
   input  wire logic [1:0]  SOURCE_SELECT,  // 01 filtered
   input  wire logic [2:0]  SUBSAMPLE,      // decimation exponent
   input  wire logic        NORMAL_MODE,    // engine in normal mode
   input  wire logic        MEAS_DONE,      // measurement finished
   input  wire logic [23:0] TEMP_RAW,       // unfiltered temperature
   input  wire logic [23:0] TEMP_FILT,      // filtered temperature
   input  wire logic [23:0] PRESS_RAW,      // unfiltered pressure
   input  wire logic [23:0] PRESS_FILT,     // filtered pressure
   input  wire logic        CONFIG_CHANGE,  // settings changed
   input  wire logic        CONFIG_ERROR,   // configuration error
   input  wire logic [23:0] SENSOR_TIME,    // time counter
   input  wire logic        CMD_WRITE,      // command register write
   input  wire logic [7:0]  CMD_CODE,       // command code
   input  wire logic        RD_START,       // burst start, loads address
   input  wire logic [7:0]  ADDR_IN,        // burst start address
   input  wire logic        RD_STROBE,      // one byte read
   input  wire logic        RD_STOP,        // burst ended
   output wire logic [7:0]  REG_ADDR,       // burst address counter
   output wire logic [7:0]  RD_DATA,        // byte from data register
   output wire logic        RD_VALID,       // RD_DATA is new
   output wire logic [7:0]  COUNT_LOW,      // byte count bits 7:0
   output wire logic [7:0]  COUNT_HIGH,     // byte count bit 8 in bit 0
   output wire logic        FULL,           // free space below frame
   output wire logic        OVERFLOW        // frame met a full store
);

   // ---------------------------------------------------------------
   // state and storage
   // ---------------------------------------------------------------
   sfb_pkg::sfb_state_t st;
   sfb_pkg::sfb_state_t nx;
   sfb_ram_if           ram ();

   logic       wr_en;
   logic [9:0] free;
   logic [6:0] ss_mask;
   logic [6:0] ss_eff;
   logic       keep;
   logic       serve;
   logic       disc;
   logic [3:0] dlen;
   logic [3:0] add;
   logic [3:0] sub_r;
   logic [3:0] len;
   logic [7:0] byte_out;
   sfb_pkg::sfb_src_t sel;

   sfb_ram u_ram (
      .clk  (CLK),
      .port (ram.store)
   );

   function automatic logic [3:0] hdr_len(input logic [7:0] h);
      logic [3:0] n;
      n = sfb_pkg::HDR_LEN;
      if (h[7:6] == sfb_pkg::TYPE_CTRL) begin
         n = sfb_pkg::CTRL_LEN;
      end else begin
         if (h[sfb_pkg::HDR_T_BIT]) begin
            n = n + sfb_pkg::QTY_LEN;
         end
         if (h[sfb_pkg::HDR_P_BIT]) begin
            n = n + sfb_pkg::QTY_LEN;
         end
      end
      return n;
   endfunction

   assign ram.raddr = st.tail + 9'(st.off);
   assign ram.haddr = st.tail;
   assign ram.waddr = st.head + 9'(st.widx);
   assign ram.wdata = st.fb[st.widx[2:0]];
   assign ram.we    = (st.wr == sfb_pkg::W_WRITE);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   assign wr_en = BUF_ENABLE && (PRESS_STORE_EN || TEMP_STORE_EN);
   assign free  = sfb_pkg::DEPTH_CNT - st.count;
   assign ss_mask = ~7'(sfb_pkg::SS_ALL << SUBSAMPLE);

   always_comb begin
      nx       = st;
      disc     = 1'b0;
      dlen     = 4'h0;
      add      = 4'h0;
      sub_r    = 4'h0;
      len      = 4'h0;
      byte_out = sfb_pkg::EMPTY_DATA;
      sel      = st.src;
      nx.rd_valid = 1'b0;
      nx.overflow = 1'b0;
      nx.norm_q   = NORMAL_MODE;

      // ---- decimation ------------------------------------------------
      // a fresh entry into normal mode restarts the count so the first
      // result after the transition is always kept
      ss_eff = (NORMAL_MODE && !st.norm_q) ? 7'h00 : st.ss_cnt;
      keep   = !NORMAL_MODE || ((ss_eff & ss_mask) == 7'h00);
      nx.ss_cnt = ss_eff;
      if (MEAS_DONE && NORMAL_MODE) begin
         nx.ss_cnt = (ss_eff + 7'h01) & ss_mask;
      end

      // ---- writer: build, check, make room, copy, commit ------------
      unique case (st.wr)
         sfb_pkg::W_IDLE: begin
            if (st.err_pend) begin
               nx.err_pend = 1'b0;
               nx.fb    = '0;
               nx.fb[0] = sfb_pkg::HDR_CFG_ERR;
               nx.fb[1] = sfb_pkg::OPC_CFG_ERR;
               nx.flen  = sfb_pkg::CTRL_LEN;
               nx.wr    = sfb_pkg::W_CHECK;
            end else if (st.meas_pend && st.chg_pend) begin
               nx.chg_pend = 1'b0;
               nx.fb    = '0;
               nx.fb[0] = sfb_pkg::HDR_CFG_CHG;
               nx.fb[1] = sfb_pkg::OPC_CFG_CHG;
               nx.flen  = sfb_pkg::CTRL_LEN;
               nx.wr    = sfb_pkg::W_CHECK;
            end else if (st.meas_pend) begin
               nx.meas_pend = 1'b0;
               nx.fb    = '0;
               nx.fb[0] = sfb_pkg::HDR_SENSOR
                        | (st.mt ? sfb_pkg::HDR_T_FLAG : 8'h00)
                        | (st.mp ? sfb_pkg::HDR_P_FLAG : 8'h00);
               nx.flen  = sfb_pkg::HDR_LEN;
               if (st.mt) begin
                  nx.fb[3:1] = st.mtemp;
                  nx.flen    = nx.flen + sfb_pkg::QTY_LEN;
               end
               if (st.mp) begin
                  if (st.mt) begin
                     nx.fb[6:4] = st.mpress;
                  end else begin
                     nx.fb[3:1] = st.mpress;
                  end
                  nx.flen = nx.flen + sfb_pkg::QTY_LEN;
               end
               nx.wr = sfb_pkg::W_CHECK;
            end
         end
         sfb_pkg::W_CHECK: begin
            nx.widx = 4'h0;
            if (free < sfb_pkg::MAX_FRAME) begin
               nx.overflow = 1'b1;
               nx.wr = STOP_ON_FULL ? sfb_pkg::W_IDLE
                                    : sfb_pkg::W_DROP;
            end else begin
               nx.wr = sfb_pkg::W_WRITE;
            end
         end
         sfb_pkg::W_DROP: begin
            // one oldest frame per cycle until the store is no longer full
            if (free < sfb_pkg::MAX_FRAME && st.count != 10'h000) begin
               disc    = 1'b1;
               dlen    = hdr_len(ram.hdata);
               nx.tail = st.tail + 9'(dlen);
               if (st.src == sfb_pkg::S_FIFO) begin
                  nx.off = 4'h0;
               end
            end else begin
               nx.wr = sfb_pkg::W_WRITE;
            end
         end
         sfb_pkg::W_WRITE: begin
            // bytes land beyond head; only the commit makes them visible
            nx.widx = st.widx + 4'h1;
            if (st.widx + 4'h1 == st.flen) begin
               nx.head = st.head + 9'(st.flen);
               add     = st.flen;
               nx.wr   = sfb_pkg::W_IDLE;
            end
         end
      endcase

      // ---- reader: address counter and frame source -----------------
      serve = 1'b0;
      if (RD_START) begin
         nx.addr      = ADDR_IN;
         nx.off       = 4'h0;
         nx.time_sent = 1'b0;
      end else if (RD_STOP) begin
         nx.off = 4'h0;
      end else if (RD_STROBE) begin
         if (st.addr == sfb_pkg::FIFO_DATA_ADDR) begin
            serve = 1'b1;
         end else begin
            nx.addr = st.addr + 8'h01;
         end
      end

      if (st.off == 4'h0) begin
         if (st.count != 10'h000) begin
            sel = sfb_pkg::S_FIFO;
         end else if (TIME_APPEND_EN && !st.time_sent) begin
            sel = sfb_pkg::S_TIME;
         end else begin
            sel = sfb_pkg::S_EMPTY;
         end
      end

      if (serve) begin
         unique case (sel)
            sfb_pkg::S_FIFO: begin
               byte_out = ram.rdata;
               len = (st.off == 4'h0) ? hdr_len(ram.rdata) : st.cur_len;
            end
            sfb_pkg::S_TIME: begin
               len = sfb_pkg::TIME_LEN;
               if (st.off == 4'h0) begin
                  byte_out = sfb_pkg::HDR_TIME;
                  nx.tcap  = SENSOR_TIME;
               end else if (st.off == sfb_pkg::TIME_B0) begin
                  byte_out = st.tcap[7:0];
               end else if (st.off == sfb_pkg::TIME_B1) begin
                  byte_out = st.tcap[15:8];
               end else begin
                  byte_out = st.tcap[23:16];
               end
            end
            sfb_pkg::S_EMPTY: begin
               len = sfb_pkg::EMPTY_LEN;
               byte_out = (st.off == 4'h0) ? sfb_pkg::HDR_EMPTY
                                           : sfb_pkg::EMPTY_DATA;
            end
         endcase
         nx.rd_data  = byte_out;
         nx.rd_valid = 1'b1;
         nx.src      = sel;
         nx.cur_len  = len;
         if (st.off + 4'h1 == len) begin
            nx.off = 4'h0;
            if (sel == sfb_pkg::S_TIME) begin
               nx.time_sent = 1'b1;
            end
            // a frame removed by streaming in this cycle is not popped again
            if (sel == sfb_pkg::S_FIFO && !disc) begin
               nx.tail = st.tail + 9'(len);
               sub_r   = len;
            end
         end else if (!(disc && sel == sfb_pkg::S_FIFO)) begin
            nx.off = st.off + 4'h1;
         end
      end

      nx.count = st.count + 10'(add) - 10'(dlen) - 10'(sub_r);

      // ---- event capture: sets after writer clears; a same-cycle flush drops measurement and error sets --
      if (MEAS_DONE && wr_en && keep) begin
         nx.meas_pend = 1'b1;
         nx.mt = TEMP_STORE_EN;
         nx.mp = PRESS_STORE_EN;
         nx.mtemp  = (SOURCE_SELECT == sfb_pkg::SRC_FILTERED)
                   ? TEMP_FILT : TEMP_RAW;
         nx.mpress = (SOURCE_SELECT == sfb_pkg::SRC_FILTERED)
                   ? PRESS_FILT : PRESS_RAW;
      end
      if (CONFIG_CHANGE && NORMAL_MODE && BUF_ENABLE) begin
         nx.chg_pend = 1'b1;
      end
      if (CONFIG_ERROR && wr_en) begin
         nx.err_pend = 1'b1;
      end

      // ---- flush works whether or not writing is enabled -------------
      if (CMD_WRITE && (CMD_CODE == sfb_pkg::CMD_FLUSH
                     || CMD_CODE == sfb_pkg::CMD_SOFTRESET)) begin
         nx.head      = 9'h000;
         nx.tail      = 9'h000;
         nx.count     = 10'h000;
         nx.off       = 4'h0;
         nx.wr        = sfb_pkg::W_IDLE;
         nx.meas_pend = 1'b0;
         nx.err_pend  = 1'b0;
      end

      nx.full = (sfb_pkg::DEPTH_CNT - nx.count) < sfb_pkg::MAX_FRAME;
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RESET) begin
         st      <= '0;
         st.wr   <= sfb_pkg::W_IDLE;
         st.src  <= sfb_pkg::S_EMPTY;
      end else begin
         st <= nx;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign REG_ADDR   = st.addr;
   assign RD_DATA    = st.rd_data;
   assign RD_VALID   = st.rd_valid;
   assign COUNT_LOW  = st.count[7:0];
   assign COUNT_HIGH = {7'h00, st.count[8]};
   assign FULL       = st.full;
   assign OVERFLOW   = st.overflow;

endmodule

// ---- logic/sfb_pkg.sv ----
package sfb_pkg;

   // ---------------------------------------------------------------
   // storage geometry
   // ---------------------------------------------------------------
   localparam int         DEPTH     = 512;
   localparam int         AW        = 9;
   localparam logic [9:0] DEPTH_CNT = 10'h200;
   localparam logic [9:0] MAX_FRAME = 10'h009;

   // ---------------------------------------------------------------
   // frame headers and payloads
   // ---------------------------------------------------------------
   localparam logic [1:0] TYPE_CTRL   = 2'h1;
   localparam int         HDR_T_BIT   = 4;
   localparam int         HDR_P_BIT   = 2;
   localparam logic [7:0] HDR_SENSOR  = 8'h80;
   localparam logic [7:0] HDR_T_FLAG  = 8'h10;
   localparam logic [7:0] HDR_P_FLAG  = 8'h04;
   localparam logic [7:0] HDR_TIME    = 8'hA0;
   localparam logic [7:0] HDR_EMPTY   = 8'h80;
   localparam logic [7:0] EMPTY_DATA  = 8'h00;
   localparam logic [7:0] HDR_CFG_ERR = 8'h44;
   localparam logic [7:0] HDR_CFG_CHG = 8'h48;
   localparam logic [7:0] OPC_CFG_ERR = 8'h01;
   localparam logic [7:0] OPC_CFG_CHG = 8'h02;
   localparam logic [3:0] HDR_LEN     = 4'h1;
   localparam logic [3:0] QTY_LEN     = 4'h3;
   localparam logic [3:0] CTRL_LEN    = 4'h2;
   localparam logic [3:0] TIME_LEN    = 4'h4;
   localparam logic [3:0] EMPTY_LEN   = 4'h2;
   localparam logic [3:0] TIME_B0     = 4'h1;
   localparam logic [3:0] TIME_B1     = 4'h2;

   // ---------------------------------------------------------------
   // settings, commands, register map
   // ---------------------------------------------------------------
   localparam logic [1:0] SRC_FILTERED   = 2'h1;
   localparam logic [6:0] SS_ALL         = 7'h7F;
   localparam logic [7:0] CMD_FLUSH      = 8'hB0;
   localparam logic [7:0] CMD_SOFTRESET  = 8'hB6;
   localparam logic [7:0] FIFO_DATA_ADDR = 8'h14;

   typedef enum logic [3:0] {
      W_IDLE  = 4'b0001,
      W_CHECK = 4'b0010,
      W_DROP  = 4'b0100,
      W_WRITE = 4'b1000
   } sfb_wr_t;

   typedef enum logic [2:0] {
      S_FIFO  = 3'b001,
      S_TIME  = 3'b010,
      S_EMPTY = 3'b100
   } sfb_src_t;

   typedef struct packed {
      sfb_wr_t         wr;
      sfb_src_t        src;
      logic [8:0]      head;
      logic [8:0]      tail;
      logic [9:0]      count;
      logic [6:0][7:0] fb;
      logic [3:0]      flen;
      logic [3:0]      widx;
      logic            meas_pend;
      logic            chg_pend;
      logic            err_pend;
      logic            mt;
      logic            mp;
      logic [23:0]     mtemp;
      logic [23:0]     mpress;
      logic [6:0]      ss_cnt;
      logic            norm_q;
      logic [7:0]      addr;
      logic [3:0]      off;
      logic [3:0]      cur_len;
      logic            time_sent;
      logic [23:0]     tcap;
      logic [7:0]      rd_data;
      logic            rd_valid;
      logic            overflow;
      logic            full;
   } sfb_state_t;

endpackage

// ---- logic/sfb_ram.sv ----
`timescale 1ns/1ns
module sfb_ram (
   input wire logic clk,  // core clock
   sfb_ram_if.store port  // one write port, two read ports
);
   logic [7:0] mem [sfb_pkg::DEPTH];

   always_ff @(posedge clk) begin
      if (port.we) begin
         mem[port.waddr] <= port.wdata;
      end
   end

   // asynchronous reads: the reader and the discard logic both need the
   // byte in the same cycle they decide on it
   assign port.rdata = mem[port.raddr];
   assign port.hdata = mem[port.haddr];
endmodule

// ---- logic/sfb_ram_if.sv ----
`timescale 1ns/1ns
interface sfb_ram_if;
   logic                   we;
   logic [sfb_pkg::AW-1:0] waddr;
   logic [7:0]             wdata;
   logic [sfb_pkg::AW-1:0] raddr;
   logic [7:0]             rdata;
   logic [sfb_pkg::AW-1:0] haddr;
   logic [7:0]             hdata;

   modport owner (output we, waddr, wdata, raddr, haddr,
                  input  rdata, hdata);
   modport store (input  we, waddr, wdata, raddr, haddr,
                  output rdata, hdata);
endinterface

// ---- tb/sfb_bench.sv ----
`timescale 1ns/1ns
module sfb_fifo_bench;
   logic        clk, reset, buf_en, p_en, t_en, stop_full, time_en;
   logic        normal, meas, chg, err, ovf_seen;
   logic [1:0]  src;
   logic [2:0]  ss;
   logic [23:0] tv, pv, stime;
   logic [9:0]  cnt;
   wire logic   rd_start, rd_strobe, rd_stop, cmd_write, rd_valid, full, ovf;
   wire logic [7:0] addr_in, cmd_code, reg_addr, rd_data, cnt_lo, cnt_hi;
   int          error_cnt, total_checks, i;
   assign cnt = {1'b0, cnt_hi[0], cnt_lo};
   sfb_fifo dut (.CLK(clk), .RESET(reset), .BUF_ENABLE(buf_en),
      .PRESS_STORE_EN(p_en), .TEMP_STORE_EN(t_en), .STOP_ON_FULL(stop_full),
      .TIME_APPEND_EN(time_en), .SOURCE_SELECT(src), .SUBSAMPLE(ss),
      .NORMAL_MODE(normal), .MEAS_DONE(meas), .TEMP_RAW(~tv), .TEMP_FILT(tv),
      .PRESS_RAW(~pv), .PRESS_FILT(pv), .CONFIG_CHANGE(chg),
      .CONFIG_ERROR(err), .SENSOR_TIME(stime), .CMD_WRITE(cmd_write),
      .CMD_CODE(cmd_code), .RD_START(rd_start), .ADDR_IN(addr_in),
      .RD_STROBE(rd_strobe), .RD_STOP(rd_stop), .REG_ADDR(reg_addr),
      .RD_DATA(rd_data), .RD_VALID(rd_valid), .COUNT_LOW(cnt_lo),
      .COUNT_HIGH(cnt_hi), .FULL(full), .OVERFLOW(ovf));
   sfb_host host (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data),
      .rd_start(rd_start), .addr_in(addr_in), .rd_strobe(rd_strobe),
      .rd_stop(rd_stop), .cmd_write(cmd_write), .cmd_code(cmd_code));
   // -------
   // helpers
   // -------
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_q(input logic [7:0] e [$]);
      chk(10'(host.got.size()), 10'(e.size()));
      foreach (e[k]) chk({2'h0, host.got[k]}, {2'h0, e[k]});
   endtask
   // inputs flip after the pulse so late sampling shows up as bad data
   task automatic pulse_meas(input logic [23:0] t, input logic [23:0] p);
      @(negedge clk);
      meas = 1'b1;
      tv = t;
      pv = p;
      @(negedge clk);
      meas = 1'b0;
      tv = ~t;
      pv = ~p;
      repeat (22) begin
         @(negedge clk);
         if (ovf === 1'b1)
            ovf_seen = 1'b1;
      end
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ---------
   // scenarios
   // ---------
   task automatic s_basic;
      pulse_meas(24'hA1B2C3, 24'hD4E5F6);
      chk(cnt, 10'h007);
      host.burst(11, 1'b0, 8'h14);
      chk_q('{8'h94, 8'hC3, 8'hB2, 8'hA1, 8'hF6, 8'hE5, 8'hD4,
              8'hA0, 8'h56, 8'h34, 8'h12});
      host.burst(6, 1'b1, 8'h14);
      chk_q('{8'hA0, 8'h56, 8'h34, 8'h12, 8'h80, 8'h00});
      chk(cnt, 10'h000);
   endtask
   task automatic s_raw_disabled;
      src = 2'h2;
      p_en = 1'b0;
      pulse_meas(24'h010203, 24'h0A0B0C);
      chk(cnt, 10'h004);
      buf_en = 1'b0;
      pulse_meas(24'h070707, 24'h070707);
      chk(cnt, 10'h004);
      time_en = 1'b0;
      host.burst(6, 1'b0, 8'h14);
      chk_q('{8'h90, 8'hFC, 8'hFD, 8'hFE, 8'h80, 8'h00});
      buf_en = 1'b1;
      t_en = 1'b0;
      pulse_meas(24'h070707, 24'h070707);
      chk(cnt, 10'h000);
      t_en = 1'b1;
      p_en = 1'b1;
      src = 2'h1;
   endtask
   task automatic s_partial_err;
      pulse_meas(24'h111111, 24'h222222);
      host.burst(3, 1'b0, 8'h14);
      chk_q('{8'h94, 8'h11, 8'h11});
      chk(cnt, 10'h007);
      host.burst(7, 1'b1, 8'h14);
      chk_q('{8'h94, 8'h11, 8'h11, 8'h11, 8'h22, 8'h22, 8'h22});
      @(negedge clk);
      err = 1'b1;
      @(negedge clk);
      err = 1'b0;
      repeat (10) @(negedge clk);
      host.burst(4, 1'b0, 8'h12);
      chk_q('{8'h44, 8'h01});
      chk({2'h0, reg_addr}, 10'h014);
   endtask
   task automatic s_flush;
      for (i = 0; i < 2; i++) begin
         pulse_meas(24'h333333, 24'h444444);
         chk(cnt, 10'h007);
         host.command(i == 0 ? 8'hB0 : 8'hB6);
         @(negedge clk);
         chk(cnt, 10'h000);
      end
   endtask
   task automatic s_decimate_change;
      normal = 1'b1;
      ss = 3'h1;
      for (i = 1; i < 4; i++) pulse_meas(24'(i), 24'h000000);
      chk(cnt, 10'h00E);
      // decimation count is left odd across a sleep visit
      normal = 1'b0;
      @(negedge clk);
      normal = 1'b1;
      @(negedge clk);
      chg = 1'b1;
      repeat (2) @(negedge clk);
      chg = 1'b0;
      pulse_meas(24'h000009, 24'h000000);
      host.burst(23, 1'b0, 8'h14);
      chk({2'h0, host.got[1]}, 10'h001);
      chk({2'h0, host.got[8]}, 10'h003);
      chk({2'h0, host.got[14]}, 10'h048);
      chk({2'h0, host.got[15]}, 10'h002);
      chk({2'h0, host.got[16]}, 10'h094);
      chk({2'h0, host.got[17]}, 10'h009);
      normal = 1'b0;
      ss = 3'h0;
   endtask
   task automatic s_full;
      stop_full = 1'b1;
      for (i = 0; i < 72; i++) pulse_meas(24'(i), 24'(i));
      chk(cnt, 10'h1F8);
      chk({9'h0, full}, 10'h001);
      ovf_seen = 1'b0;
      pulse_meas(24'h0000FF, 24'h0000FF);
      chk({9'h0, ovf_seen}, 10'h001);
      chk(cnt, 10'h1F8);
      stop_full = 1'b0;
      pulse_meas(24'h0000EE, 24'h0000EE);
      chk(cnt, 10'h1F8);
      host.burst(7, 1'b0, 8'h14);
      chk({2'h0, host.got[1]}, 10'h001);
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (30000) @(posedge clk);
      error_cnt++;
      test_done;
   end
   initial begin
      {reset, buf_en, p_en, t_en, time_en} = 5'h1F;
      {stop_full, normal, meas, chg, err, ovf_seen} = 6'h00;
      src = 2'h1;
      ss = 3'h0;
      tv = 24'h000000;
      pv = 24'h000000;
      stime = 24'h123456;
      repeat (20) @(negedge clk);
      reset = 1'b0;
      s_basic;
      s_raw_disabled;
      s_partial_err;
      s_flush;
      s_decimate_change;
      s_full;
      test_done;
   end
endmodule

// ---- tb/sfb_fifo_chk.sv ----
`timescale 1ns/1ns
module sfb_fifo_chk (
   input wire logic       CLK,        // core clock
   input wire logic       RESET,      // sync reset
   input wire logic       RD_START,   // burst start
   input wire logic       RD_STROBE,  // byte read
   input wire logic       RD_STOP,    // burst end
   input wire logic       CMD_WRITE,  // command write
   input wire logic [7:0] CMD_CODE,   // command code
   input wire logic [7:0] REG_ADDR,   // address counter
   input wire logic       RD_VALID,   // byte served
   input wire logic [7:0] COUNT_LOW,  // count low
   input wire logic [7:0] COUNT_HIGH, // count msb
   input wire logic       FULL,       // full level
   input wire logic       OVERFLOW    // overflow pulse
);
   // ----------
   // properties
   // ----------
   logic [9:0] cnt;
   logic       rd;
   assign cnt = {1'b0, COUNT_HIGH[0], COUNT_LOW};
   // start and stop win over a strobe in the same cycle
   assign rd  = RD_STROBE && !RD_START && !RD_STOP;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   a_addr_holds_data: assert property (
      rd && REG_ADDR == 8'h14 |=> REG_ADDR == 8'h14 && RD_VALID)
      else $error("address left the data register");
   a_addr_advances: assert property (
      rd && REG_ADDR != 8'h14 |=>
      REG_ADDR == $past(REG_ADDR) + 8'h01 && !RD_VALID)
      else $error("address did not advance");
   a_valid_source: assert property (
      RD_VALID |-> $past(rd) && $past(REG_ADDR) == 8'h14)
      else $error("byte served without a data read");
   a_count_msb_only: assert property (
      COUNT_HIGH[7:1] == 7'h00)
      else $error("count high register upper bits set");
   a_count_bound: assert property (cnt <= 10'h200)
      else $error("count above store size");
   a_full_level: assert property (
      FULL == (cnt > 10'h1F7))
      else $error("full flag disagrees with count");
   // a pop can share the commit edge; such edges carry a served byte
   a_count_whole: assert property (
      cnt > $past(cnt) && !RD_VALID |->
      (cnt - $past(cnt)) inside {10'h002, 10'h004, 10'h007})
      else $error("count rose by a partial frame");
   a_flush_empties: assert property (
      CMD_WRITE && (CMD_CODE == 8'hB0 || CMD_CODE == 8'hB6) |=>
      cnt == 10'h000)
      else $error("flush left bytes stored");
   a_overflow_full: assert property (OVERFLOW |-> $past(FULL))
      else $error("overflow without full store");
   c_data_read: cover property (rd && REG_ADDR == 8'h14);
   c_overflow: cover property (OVERFLOW);
   c_full: cover property (FULL);
endmodule

bind sfb_fifo sfb_fifo_chk chk (.CLK(CLK), .RESET(RESET),
   .RD_START(RD_START), .RD_STROBE(RD_STROBE), .RD_STOP(RD_STOP),
   .CMD_WRITE(CMD_WRITE), .CMD_CODE(CMD_CODE), .REG_ADDR(REG_ADDR),
   .RD_VALID(RD_VALID), .COUNT_LOW(COUNT_LOW), .COUNT_HIGH(COUNT_HIGH),
   .FULL(FULL), .OVERFLOW(OVERFLOW));

// ---- tb/sfb_host.sv ----
`timescale 1ns/1ns
module sfb_host (
   input  wire logic       clk,       // core clock
   input  wire logic       rd_valid,  // byte served
   input  wire logic [7:0] rd_data,   // served byte
   output logic            rd_start,  // burst start
   output logic [7:0]      addr_in,   // start address
   output logic            rd_strobe, // byte read
   output logic            rd_stop,   // burst end
   output logic            cmd_write, // command write
   output logic [7:0]      cmd_code   // command code
);
   logic [7:0] got [$];
   initial begin
      rd_start = 1'b0;
      rd_strobe = 1'b0;
      rd_stop = 1'b0;
      cmd_write = 1'b0;
      cmd_code = 8'h00;
      addr_in = 8'hEB;
   end
   // slow bursts leave an idle cycle between strobes
   task automatic burst(input int n, input bit slow, input logic [7:0] start);
      int i;
      got.delete();
      @(negedge clk);
      rd_start = 1'b1;
      addr_in = start;
      @(negedge clk);
      rd_start = 1'b0;
      addr_in = 8'hEB;
      for (i = 0; i < 2 * n + 1; i++) begin
         rd_strobe = (i < (slow ? 2 * n : n)) && (!slow || i % 2 == 0);
         @(negedge clk);
         if (rd_valid === 1'b1)
            got.push_back(rd_data);
      end
      rd_stop = 1'b1;
      @(negedge clk);
      rd_stop = 1'b0;
   endtask
   task automatic command(input logic [7:0] code);
      @(negedge clk);
      cmd_write = 1'b1;
      cmd_code = code;
      @(negedge clk);
      cmd_write = 1'b0;
      cmd_code = 8'h00;
   endtask
endmodule
